// *** hdl/csd_pkg.sv ***
// Constants shared by the CPU clock select and divider logic.
// Assumes a single core clock; oscillator activity arrives as enable pulses.
package csd_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [19:0] CTRL_ADDR = 20'hF_FFA4;
  localparam logic [7:0] CTRL_RESET = 8'h09;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CPU_STAT_BIT = 7;
  localparam int SUB_SEL_BIT = 6;
  localparam int MAIN_STAT_BIT = 5;
  localparam int MAIN_SRC_BIT = 4;
  localparam int FIXED_BIT = 3;
  localparam int DIV_LSB = 0;
  localparam logic FIXED_VAL = 1'h1;
  // Writable bits; bits 7, 5 and 3 are not
  localparam logic [7:0] WRITE_MASK = 8'h57;
  // Largest legal divider code (divide by 32)
  localparam logic [2:0] DIV_MAX = 3'h5;
  // Subsystem path always divides by two
  localparam logic [2:0] SUB_DIV = 3'h1;
endpackage

// *** hdl/csd_divider.sv ***
// Power-of-two divider driven by a source tick pulse.
// Assumes tick is a one-cycle enable on core_clk from the selected oscillator.
`timescale 1ns/1ps
module csd_divider #(
  parameter int CNT_W = 5
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Source and ratio
  input wire logic tick,
  input wire logic [2:0] code,
  // Divided enable, combinational from the counter
  output logic pulse
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] mask;
  logic [2:0] eff;

  always_comb begin
    // Prohibited codes fall back to the slowest legal ratio
    eff = (code > csd_pkg::DIV_MAX) ? csd_pkg::DIV_MAX : code;
    mask = CNT_W'((32'h0000_0001 << eff) - 32'h0000_0001);
    pulse = tick && ((cnt_reg & mask) == mask);
    cnt_next = tick ? cnt_reg + 1'b1 : cnt_reg;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// *** hdl/csd_clock_select.sv ***
// CPU/peripheral clock selection: control register, source switch and divider.
// Assumes oscillator activity arrives as one-cycle tick pulses on core_clk.
`timescale 1ns/1ps
module csd_clock_select (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [19:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] wmask,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Oscillator ticks and fast internal select
  input wire logic internal_high_speed_clock,
  input wire logic fast_internal_clock,
  input wire logic high_speed_system_clock,
  input wire logic subsystem_clock,
  input wire logic fast_internal_select,
  // Clock outputs and status
  output logic cpu_peripheral_clock,
  output logic main_clock_status,
  output logic cpu_clock_status
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic cls_reg, cls_next;
  logic css_reg, css_next;
  logic mcs_reg, mcs_next;
  logic mcm_reg, mcm_next;
  logic [2:0] div_reg, div_next;
  logic [7:0] rdata_reg, rdata_next;
  logic clk_en_reg, clk_en_next;
  logic hit;
  logic [7:0] cur;
  logic [7:0] merged;
  logic internal_tick;
  logic main_tick;
  logic main_target_tick;
  logic cpu_target_tick;
  logic main_pulse;
  logic sub_pulse;

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  assign internal_tick = fast_internal_select ? fast_internal_clock
                                              : internal_high_speed_clock;
  // Main path follows the active status, not the request, so no runt edges
  assign main_tick = mcs_reg ? high_speed_system_clock : internal_tick;
  assign main_target_tick = mcm_reg ? high_speed_system_clock : internal_tick;
  assign cpu_target_tick = css_reg ? subsystem_clock : main_tick;

  csd_divider u_main_div (
    .core_clk(core_clk),
    .rst(rst),
    .tick(main_tick),
    .code(div_reg),
    .pulse(main_pulse)
  );

  csd_divider u_sub_div (
    .core_clk(core_clk),
    .rst(rst),
    .tick(subsystem_clock),
    .code(csd_pkg::SUB_DIV),
    .pulse(sub_pulse)
  );

  // ----------------------------------------------------------------
  // Register and switch logic
  // ----------------------------------------------------------------
  always_comb begin
    hit = (addr == csd_pkg::CTRL_ADDR);
    cur = {cls_reg, css_reg, mcs_reg, mcm_reg, csd_pkg::FIXED_VAL, div_reg};
    // Mask limits a bit write to one lane; status bits never take data
    merged = (cur & ~(wmask & csd_pkg::WRITE_MASK))
           | (wdata & wmask & csd_pkg::WRITE_MASK);
    css_next = css_reg;
    mcm_next = mcm_reg;
    div_next = div_reg;
    if (wr && hit) begin
      css_next = merged[csd_pkg::SUB_SEL_BIT];
      mcm_next = merged[csd_pkg::MAIN_SRC_BIT];
      div_next = merged[csd_pkg::DIV_LSB +: 3];
    end
    // Status follows a request only on a tick of the clock it names
    mcs_next = (mcm_reg != mcs_reg && main_target_tick) ? mcm_reg : mcs_reg;
    cls_next = (css_reg != cls_reg && cpu_target_tick) ? css_reg : cls_reg;
    // Subsystem path is fixed at divide by two
    clk_en_next = cls_reg ? sub_pulse : main_pulse;
    rdata_next = (rd && hit) ? cur : 8'h00;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cls_reg <= csd_pkg::CTRL_RESET[csd_pkg::CPU_STAT_BIT];
      css_reg <= csd_pkg::CTRL_RESET[csd_pkg::SUB_SEL_BIT];
      mcs_reg <= csd_pkg::CTRL_RESET[csd_pkg::MAIN_STAT_BIT];
      mcm_reg <= csd_pkg::CTRL_RESET[csd_pkg::MAIN_SRC_BIT];
      div_reg <= csd_pkg::CTRL_RESET[csd_pkg::DIV_LSB +: 3];
      rdata_reg <= 8'h00;
      clk_en_reg <= 1'b0;
    end else begin
      cls_reg <= cls_next;
      css_reg <= css_next;
      mcs_reg <= mcs_next;
      mcm_reg <= mcm_next;
      div_reg <= div_next;
      rdata_reg <= rdata_next;
      clk_en_reg <= clk_en_next;
    end
  end

  assign rdata = rdata_reg;
  assign cpu_peripheral_clock = clk_en_reg;
  assign main_clock_status = mcs_reg;
  assign cpu_clock_status = cls_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_RESET_VALUE: assert property (@(posedge core_clk) rst |=> (!cls_reg && !css_reg
      && !mcs_reg && !mcm_reg && div_reg == 3'h1 && !clk_en_reg))
    else $error("control register not at reset value");

  AST_BIT_WRITE: assert property (@(posedge core_clk) disable iff (rst)
      (wr && hit && wmask == 8'h10) |=> (mcm_reg == $past(wdata[4])
      && css_reg == $past(css_reg) && div_reg == $past(div_reg)))
    else $error("single bit write disturbed other bits");

  AST_STATUS_READ_ONLY: assert property (@(posedge core_clk) disable iff (rst)
      (wr && hit && !main_target_tick && !cpu_target_tick)
      |=> ($stable(mcs_reg) && $stable(cls_reg)))
    else $error("write changed a status bit");

  AST_CPU_STATUS_READ: assert property (@(posedge core_clk) disable iff (rst)
      (rd && hit) |=> (rdata[7] == $past(cls_reg) && rdata[3]))
    else $error("cpu status read mismatch");

  AST_MAIN_STATUS_READ: assert property (@(posedge core_clk) disable iff (rst)
      (rd && hit) |=> (rdata[5] == $past(mcs_reg) && rdata[4] == $past(mcm_reg)))
    else $error("main status read mismatch");

  AST_MAIN_SOURCE: assert property (@(posedge core_clk) disable iff (rst)
      (mcs_reg && !cls_reg && div_reg == 3'h0)
      |=> (clk_en_reg == $past(high_speed_system_clock)))
    else $error("main path not on high speed clock");

  AST_DIV_ONE: assert property (@(posedge core_clk) disable iff (rst)
      (!cls_reg && div_reg == 3'h0 && main_tick) |=> clk_en_reg)
    else $error("divide by one dropped a tick");

  AST_SWITCH_ON_TICK: assert property (@(posedge core_clk) disable iff (rst)
      (!$past(rst) && $changed(mcs_reg)) |-> ($past(main_target_tick)
      && mcs_reg == $past(mcm_reg)))
    else $error("main status changed without target tick");

  AST_SUB_SWITCH: assert property (@(posedge core_clk) disable iff (rst)
      (css_reg && !cls_reg && subsystem_clock) |=> cls_reg ##1 cls_reg)
    else $error("cpu status missed subsystem switch");
endmodule

// *** testbench/csd_clock_select_tb.sv ***
// Self-checking bench for the CPU clock select and divider block.
// Assumes ticks may be held high to mean one tick in every core_clk cycle.
`timescale 1ns/1ps
module csd_clock_select_tb;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [19:0] addr = '0;
  logic [7:0] wdata = '0;
  logic [7:0] wmask = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic ih = 1'b0;
  logic hs = 1'b0;
  logic sb = 1'b0;
  logic fi = 1'b0;
  logic fsel = 1'b0;
  logic cpu_peripheral_clock;
  logic main_clock_status;
  logic cpu_clock_status;
  int bad_count = 0;
  int n_compared = 0;
  localparam logic [19:0] A = csd_pkg::CTRL_ADDR;

  always #20 core_clk = ~core_clk;

  csd_clock_select i_csd_clock_select (.core_clk(core_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wmask(wmask), .wr(wr), .rd(rd), .rdata(rdata),
    .internal_high_speed_clock(ih), .fast_internal_clock(fi),
    .high_speed_system_clock(hs), .subsystem_clock(sb), .fast_internal_select(fsel),
    .cpu_peripheral_clock(cpu_peripheral_clock), .main_clock_status(main_clock_status),
    .cpu_clock_status(cpu_clock_status));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic wr_reg(input logic [19:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wmask <= m;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Settle first: the divider phase is not reset when the ratio changes
  task automatic count_pulses(input int exp);
    int n;
    n = 0;
    repeat (64) @(posedge core_clk);
    repeat (64) begin
      @(posedge core_clk);
      #1;
      if (cpu_peripheral_clock === 1'b1) begin
        n++;
      end
    end
    chk(n[7:0], exp[7:0]);
  endtask

  task automatic tally_and_finish;
    $display("compared %0d, errors %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(A, 8'h09);
    rd_chk(20'h0_0000, 8'h00);
    ih <= 1'b1;
    for (int d = 0; d < 6; d++) begin
      wr_reg(A, 8'(d), 8'h07);
      count_pulses(64 >> d);
    end
    wr_reg(A, 8'hA0, 8'hFF);
    rd_chk(A, 8'h08);
    wr_reg(A, 8'hFF, 8'h01);
    rd_chk(A, 8'h09);
    wr_reg(A, 8'h10, 8'h10);
    rd_chk(A, 8'h19);
    hs <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(8'(main_clock_status), 8'h01);
    rd_chk(A, 8'h39);
    ih <= 1'b0;
    count_pulses(32);
    sb <= 1'b0;
    wr_reg(A, 8'h45, 8'h47);
    rd_chk(A, 8'h7D);
    sb <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(8'(cpu_clock_status), 8'h01);
    rd_chk(A, 8'hFD);
    count_pulses(32);
    sb <= 1'b0;
    wr_reg(A, 8'h00, 8'h40);
    repeat (4) @(posedge core_clk);
    rd_chk(A, 8'h3D);
    // Main path on the high-speed clock: internal ticks must not reach it
    wr_reg(A, 8'h00, 8'h07);
    count_pulses(64);
    hs <= 1'b0;
    ih <= 1'b1;
    count_pulses(0);
    // Ordinary internal clock first, the only way towards the fast one
    wr_reg(A, 8'h00, 8'h10);
    repeat (4) @(posedge core_clk);
    rd_chk(A, 8'h08);
    // Subsystem round trip with the internal oscillator running as main
    wr_reg(A, 8'h40, 8'h40);
    sb <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(8'(cpu_clock_status), 8'h01);
    sb <= 1'b0;
    wr_reg(A, 8'h00, 8'h40);
    repeat (4) @(posedge core_clk);
    rd_chk(A, 8'h08);
    fsel <= 1'b1;
    fi <= 1'b1;
    ih <= 1'b0;
    count_pulses(64);
    // Leave the fast clock by clearing its select, then stop it
    fsel <= 1'b0;
    repeat (2) @(posedge core_clk);
    fi <= 1'b0;
    // With every source quiet a write cannot move a status bit
    wr_reg(A, 8'hA0, 8'hA0);
    rd_chk(A, 8'h08);
    tally_and_finish();
  end

  // Whole run needs about 1,500 cycles
  initial begin
    #(40 * 4000);
    bad_count++;
    tally_and_finish();
  end
endmodule
